/* common/sacs_pkg.sv */
// constants and types shared by the converter control sequencer
package sacs_pkg;

	//////////////////////////////////////////////////////////////////////
	// sizes
	localparam int RES_BITS = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PIN_FN_W = 14;
	localparam int CHAN_W = 5;
	localparam int DIV_CNT_W = 6;

	//////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFS_WAKE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h15;
	localparam logic [7:0] OFS_MASK = 8'h1B;
	localparam logic [7:0] OFS_CFG_ONE = 8'h3E;
	localparam logic [7:0] OFS_CFG_TWO = 8'h3F;
	localparam logic [7:0] OFS_CHANNEL = 8'h40;
	localparam logic [7:0] OFS_PIN_LO = 8'h41;
	localparam logic [7:0] OFS_PIN_HI = 8'h42;
	localparam logic [7:0] OFS_RES_HI = 8'h44;
	localparam logic [7:0] OFS_RES_LO = 8'h45;

	//////////////////////////////////////////////////////////////////////
	// field positions
	localparam int RATE_LSB = 5;
	localparam int RUN_BIT = 4;
	localparam int POWER_BIT = 3;
	localparam int AUX_ONE_BIT = 2;
	localparam int AUX_TWO_LSB = 4;
	localparam int REF_SRC_LSB = 2;
	localparam int REF_PIN_BIT = 1;
	localparam int EVENT_BIT = 4;

	//////////////////////////////////////////////////////////////////////
	// reset values and vector
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CONV_IRQ_VECTOR = 8'h10;

	//////////////////////////////////////////////////////////////////////
	// conversion clock rate codes
	localparam logic [2:0] RATE_DIV16 = 3'h0;
	localparam logic [2:0] RATE_DIV8 = 3'h1;
	localparam logic [2:0] RATE_DIV4 = 3'h2;
	localparam logic [2:0] RATE_DIV2 = 3'h3;
	localparam logic [2:0] RATE_DIV64 = 3'h4;
	localparam logic [2:0] RATE_DIV32 = 3'h5;
	localparam logic [2:0] RATE_DIV1 = 3'h6;
	localparam logic [2:0] RATE_SUB = 3'h7;

	typedef enum logic [1:0] {
		SAR_IDLE = 2'h0,
		SAR_CONV = 2'h1
	} sacs_sar_state_t;

	// main clock divide factor for a rate code
	function automatic int rate_divisor(input logic [2:0] rate);
		case (rate)
			RATE_DIV16: rate_divisor = 16;
			RATE_DIV8: rate_divisor = 8;
			RATE_DIV4: rate_divisor = 4;
			RATE_DIV2: rate_divisor = 2;
			RATE_DIV64: rate_divisor = 64;
			RATE_DIV32: rate_divisor = 32;
			default: rate_divisor = 1;
		endcase
	endfunction : rate_divisor

endpackage : sacs_pkg

/* logic/sacs_clkdiv.sv */
// conversion clock enable generator
`timescale 1ns/100ps
module sacs_clkdiv
	import sacs_pkg::*;
#(
	parameter int CNT_W = DIV_CNT_W
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// setup
	input wire logic i_enable,
	input wire logic [2:0] i_rate,
	input wire logic i_green,
	input wire logic i_sub_tick,
	// conversion clock enable
	output logic o_tick
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] limit;
	logic use_sub;

	assign use_sub = i_green || (i_rate == RATE_SUB);
	assign limit = CNT_W'(rate_divisor(i_rate) - 1);

	always_ff @(posedge i_clock) begin
		if (!i_rst_b || !i_enable) begin
			cnt <= '0;
			o_tick <= 1'b0;
		end else if (use_sub) begin
			cnt <= '0;
			o_tick <= i_sub_tick;
		end else if (cnt >= limit) begin
			cnt <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt <= cnt + CNT_W'(1);
			o_tick <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	div_one_a: assert property (
		i_enable && !use_sub && i_rate == RATE_DIV1 |=> o_tick)
		else $error("divide by one misses a tick");

	sub_clock_a: assert property (
		i_enable && use_sub |=> o_tick == $past(i_sub_tick))
		else $error("sub clock tick not followed");

	div_two_a: assert property (
		i_enable && !use_sub && i_rate == RATE_DIV2 && o_tick |=> !o_tick)
		else $error("divide by two ticks back to back");

endmodule : sacs_clkdiv

/* logic/sacs_sar.sv */
// successive approximation sequencer
`timescale 1ns/100ps
module sacs_sar
	import sacs_pkg::*;
#(
	parameter int WIDTH = RES_BITS
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// control
	input wire logic i_start,
	input wire logic i_tick,
	input wire logic i_cmp_high,
	// status and data
	output logic o_busy,
	output logic o_done,
	output logic [WIDTH-1:0] o_trial,
	output logic [WIDTH-1:0] o_result
);

	localparam int IW = $clog2(WIDTH);

	sacs_sar_state_t state;
	logic [IW-1:0] idx;
	logic last;
	logic [IW:0] ticks_seen;

	assign last = (state == SAR_CONV) && i_tick && (idx == '0);

	// one bit decided per conversion clock, msb first
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			state <= SAR_IDLE;
			idx <= '0;
			o_trial <= '0;
		end else begin
			case (state)
				SAR_IDLE: begin
					if (i_start) begin
						o_trial <= {1'b1, {(WIDTH-1){1'b0}}};
						idx <= IW'(WIDTH - 1);
						state <= SAR_CONV;
					end
				end
				SAR_CONV: begin
					if (i_tick) begin
						o_trial[idx] <= i_cmp_high;
						if (idx == '0) begin
							state <= SAR_IDLE;
						end else begin
							o_trial[idx - IW'(1)] <= 1'b1;
							idx <= idx - IW'(1);
						end
					end
				end
				default: state <= SAR_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_result <= '0;
		end else begin
			o_done <= last;
			if (state == SAR_IDLE && i_start) begin
				o_busy <= 1'b1;
			end else if (last) begin
				o_busy <= 1'b0;
				o_result <= {o_trial[WIDTH-1:1], i_cmp_high};
			end
		end
	end

	// helper for the length check
	always_ff @(posedge i_clock) begin
		if (!i_rst_b || (state == SAR_IDLE && i_start)) begin
			ticks_seen <= '0;
		end else if (state == SAR_CONV && i_tick) begin
			ticks_seen <= ticks_seen + (IW+1)'(1);
		end
	end

	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	sar_length_a: assert property (
		o_done |-> ticks_seen == (IW+1)'(WIDTH))
		else $error("conversion did not take one tick per bit");

	sar_msb_a: assert property (
		state == SAR_IDLE && i_start |=>
		o_busy && o_trial == {1'b1, {(WIDTH-1){1'b0}}})
		else $error("conversion did not start at the msb");

	sar_busy_a: assert property (
		o_busy && !last |=> o_busy)
		else $error("busy dropped before the last bit");

endmodule : sacs_sar

/* logic/sacs_top.sv */
// converter control sequencer: registers, sleep and interrupt handling
//
// Operation
// - resolve each sample to twelve bits
// - reference from supply or pin, by field
// - load result registers at completion
// - set done flag at completion if enabled
// - rate field picks divider or sub clock; green mode forces sub clock
// - conversion keeps running during sleep
// - clear run bit at completion
// - wake if enabled, else shut converter off
// - wake without vector when global irq off
// - vector on completion when global irq on
// - channel change during readout clears results
// - global irq enable, disable, own vector
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module sacs_top
	import sacs_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	// core events
	input wire logic i_sleep_instr,
	input wire logic i_eni_instr,
	input wire logic i_global_irq_disable_instr_instr,
	input wire logic i_green_mode,
	input wire logic i_sub_tick,
	// analog side
	input wire logic i_cmp_high,
	output logic [RES_BITS-1:0] o_trial_code,
	output logic o_sample_enable,
	output logic [CHAN_W-1:0] o_channel_select,
	output logic [PIN_FN_W-1:0] o_pin_function_bits,
	output logic [1:0] o_sample_hold_select,
	output logic o_ref_pin_select,
	output logic [1:0] o_ref_source_field,
	output logic o_conv_active,
	// core control
	output logic o_core_sleep,
	output logic o_wake,
	output logic o_resume_next,
	output logic o_irq_request,
	output logic [7:0] o_irq_vector,
	output logic o_global_irq_enable
);

	//////////////////////////////////////////////////////////////////////
	// register state

	logic [2:0] conv_clock_rate;
	logic conv_power_up;
	logic cfg_aux_one;
	logic [1:0] cfg_aux_two;
	logic conv_wake_enable;
	logic conv_irq_enable;
	logic conv_done_flag;
	logic [RES_BITS-1:0] result;
	logic shut_off;

	logic [DATA_W-1:0] next_rdata;
	logic wr_cfg_one;
	logic wr_cfg_two;
	logic wr_channel;
	logic wr_status;
	logic start;
	logic chan_clear;

	logic conv_tick;
	logic sar_busy;
	logic sar_done;
	logic [RES_BITS-1:0] sar_result;

	assign wr_cfg_one = i_wr && (i_addr == OFS_CFG_ONE);
	assign wr_cfg_two = i_wr && (i_addr == OFS_CFG_TWO);
	assign wr_channel = i_wr && (i_addr == OFS_CHANNEL);
	assign wr_status = i_wr && (i_addr == OFS_STATUS);

	// writing a one to run starts a conversion when powered and idle
	assign start = wr_cfg_one && i_wdata[RUN_BIT] &&
		i_wdata[POWER_BIT] && !sar_busy;

	// new channel while a result waits to be read
	assign chan_clear = wr_channel && conv_done_flag &&
		(i_wdata[CHAN_W-1:0] != o_channel_select);

	//////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			conv_clock_rate <= REG_RESET[2:0];
			conv_power_up <= 1'b0;
			cfg_aux_one <= 1'b0;
			o_sample_hold_select <= REG_RESET[1:0];
		end else if (wr_cfg_one) begin
			conv_clock_rate <= i_wdata[RATE_LSB +: 3];
			conv_power_up <= i_wdata[POWER_BIT];
			cfg_aux_one <= i_wdata[AUX_ONE_BIT];
			o_sample_hold_select <= i_wdata[1:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			cfg_aux_two <= REG_RESET[1:0];
			o_ref_source_field <= REG_RESET[1:0];
			o_ref_pin_select <= 1'b0;
		end else if (wr_cfg_two) begin
			cfg_aux_two <= i_wdata[AUX_TWO_LSB +: 2];
			o_ref_source_field <= i_wdata[REF_SRC_LSB +: 2];
			o_ref_pin_select <= i_wdata[REF_PIN_BIT];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_channel_select <= REG_RESET[CHAN_W-1:0];
		end else if (wr_channel) begin
			o_channel_select <= i_wdata[CHAN_W-1:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_pin_function_bits <= {REG_RESET[5:0], REG_RESET};
		end else if (i_wr && i_addr == OFS_PIN_LO) begin
			o_pin_function_bits[7:0] <= i_wdata;
		end else if (i_wr && i_addr == OFS_PIN_HI) begin
			o_pin_function_bits[PIN_FN_W-1:8] <= i_wdata[5:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			conv_wake_enable <= 1'b0;
			conv_irq_enable <= 1'b0;
		end else if (i_wr && i_addr == OFS_WAKE) begin
			conv_wake_enable <= i_wdata[EVENT_BIT];
		end else if (i_wr && i_addr == OFS_MASK) begin
			conv_irq_enable <= i_wdata[EVENT_BIT];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// result and completion flag

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			result <= '0;
		end else if (sar_done) begin
			result <= sar_result;
		end else if (chan_clear) begin
			result <= '0;
		end
	end

	// hardware set wins over a software clear
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			conv_done_flag <= 1'b0;
		end else if (sar_done && conv_irq_enable) begin
			conv_done_flag <= 1'b1;
		end else if (wr_status && !i_wdata[EVENT_BIT]) begin
			conv_done_flag <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// sleep, wake and interrupt

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_global_irq_enable <= 1'b0;
		end else if (i_eni_instr) begin
			o_global_irq_enable <= 1'b1;
		end else if (i_global_irq_disable_instr_instr) begin
			o_global_irq_enable <= 1'b0;
		end
	end

	// converter keeps running while asleep
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_core_sleep <= 1'b0;
		end else if (sar_done && o_core_sleep && conv_wake_enable) begin
			o_core_sleep <= 1'b0;
		end else if (i_sleep_instr) begin
			o_core_sleep <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			shut_off <= 1'b0;
		end else if (sar_done && o_core_sleep && !conv_wake_enable) begin
			shut_off <= 1'b1;
		end else if (wr_cfg_one && i_wdata[POWER_BIT]) begin
			shut_off <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_wake <= 1'b0;
			o_resume_next <= 1'b0;
			o_irq_request <= 1'b0;
			o_irq_vector <= REG_RESET;
		end else begin
			o_wake <= sar_done && o_core_sleep &&
				conv_wake_enable;
			o_resume_next <= sar_done && o_core_sleep &&
				conv_wake_enable && conv_irq_enable &&
				!o_global_irq_enable;
			o_irq_request <= sar_done && conv_irq_enable &&
				o_global_irq_enable &&
				(!o_core_sleep || conv_wake_enable);
			if (sar_done && conv_irq_enable && o_global_irq_enable) begin
				o_irq_vector <= CONV_IRQ_VECTOR;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_sample_enable <= 1'b0;
			o_conv_active <= 1'b0;
		end else begin
			o_sample_enable <= conv_power_up && !shut_off;
			o_conv_active <= start || (sar_busy && !sar_done);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// register read port

	always_comb begin
		next_rdata = REG_RESET;
		case (i_addr)
			OFS_CFG_ONE: next_rdata = {conv_clock_rate, sar_busy,
				conv_power_up, cfg_aux_one,
				o_sample_hold_select};
			OFS_CFG_TWO: next_rdata = {2'h0, cfg_aux_two,
				o_ref_source_field, o_ref_pin_select, 1'b0};
			OFS_CHANNEL: next_rdata = {3'h0, o_channel_select};
			OFS_PIN_LO: next_rdata = o_pin_function_bits[7:0];
			OFS_PIN_HI: next_rdata = {2'h0,
				o_pin_function_bits[PIN_FN_W-1:8]};
			OFS_RES_HI: next_rdata = {4'h0, result[11:8]};
			OFS_RES_LO: next_rdata = result[7:0];
			OFS_WAKE: next_rdata = {3'h0, conv_wake_enable, 4'h0};
			OFS_STATUS: next_rdata = {3'h0, conv_done_flag, 4'h0};
			OFS_MASK: next_rdata = {3'h0, conv_irq_enable, 4'h0};
			default: next_rdata = REG_RESET;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_rdata <= REG_RESET;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= REG_RESET;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// conversion clock and sequencer

	sacs_clkdiv u_clkdiv (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_enable(sar_busy),
		.i_rate(conv_clock_rate),
		.i_green(i_green_mode),
		.i_sub_tick(i_sub_tick),
		.o_tick(conv_tick)
	);

	sacs_sar u_sar (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_start(start),
		.i_tick(conv_tick),
		.i_cmp_high(i_cmp_high),
		.o_busy(sar_busy),
		.o_done(sar_done),
		.o_trial(o_trial_code),
		.o_result(sar_result)
	);

	//////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	sequence s_start;
		i_wr && i_addr == OFS_CFG_ONE && i_wdata[RUN_BIT] &&
		i_wdata[POWER_BIT] && !sar_busy;
	endsequence

	sequence s_run_read;
		i_rd && i_addr == OFS_CFG_ONE;
	endsequence

	start_run_a: assert property (
		s_start ##1 s_run_read |=> o_rdata[RUN_BIT])
		else $error("run bit not set after start");

	run_clear_a: assert property (
		sar_done ##0 (!i_wr) ##1 s_run_read |=> !o_rdata[RUN_BIT])
		else $error("run bit still set after completion");

	result_load_a: assert property (
		sar_done |=> result == $past(sar_result))
		else $error("result not loaded at completion");

	flag_set_a: assert property (
		sar_done && conv_irq_enable |=> conv_done_flag)
		else $error("done flag not set at completion");

	wake_up_a: assert property (
		sar_done && o_core_sleep && conv_wake_enable |=>
		o_wake && !o_core_sleep)
		else $error("no wake at completion in sleep");

	shut_off_a: assert property (
		sar_done && o_core_sleep && !conv_wake_enable &&
		!(wr_cfg_one && i_wdata[POWER_BIT]) |=> ##1 !o_sample_enable)
		else $error("converter not shut off in sleep");

	resume_next_a: assert property (
		o_resume_next |-> o_wake && !o_irq_request)
		else $error("resume without wake or with vector");

	irq_vector_a: assert property (
		sar_done && conv_irq_enable && o_global_irq_enable &&
		!o_core_sleep |=> o_irq_request &&
		o_irq_vector == CONV_IRQ_VECTOR)
		else $error("no vector on completion");

	global_en_a: assert property (
		i_eni_instr |=> o_global_irq_enable)
		else $error("global enable not set");

	chan_clear_a: assert property (
		chan_clear && !sar_done |=> result == '0)
		else $error("results not cleared on channel change");

	ref_select_a: assert property (
		wr_cfg_two |=> o_ref_pin_select == $past(i_wdata[REF_PIN_BIT]))
		else $error("reference pin select not taken");

endmodule : sacs_top

/* test/sacs_top_bench.sv */
// self-checking bench for the converter control sequencer
`timescale 1ns/100ps
`define SACS_CHK(n, e, g) chk(n, e, g)
module sacs_top_bench
	import sacs_pkg::*;
;
	//////////////////////////////////////////////////////////////////////
	logic i_clock, i_rst_b, i_wr, i_rd, i_green_mode, i_sub_tick;
	logic i_sleep_instr, i_eni_instr, i_global_irq_disable_instr_instr, i_cmp_high;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata;
	logic [RES_BITS-1:0] o_trial_code, analog;
	logic [CHAN_W-1:0] o_channel_select;
	logic [PIN_FN_W-1:0] o_pin_function_bits;
	logic [1:0] o_sample_hold_select, o_ref_source_field;
	logic o_sample_enable, o_ref_pin_select, o_conv_active, o_core_sleep;
	logic o_wake, o_resume_next, o_irq_request, o_global_irq_enable;
	logic [7:0] o_irq_vector;
	logic [2:0] sub_cnt;
	int err_total, checks_done, n_wake, n_irq, n_resume;

	// comparator: analog level against the trial code
	assign i_cmp_high = (analog >= o_trial_code);

	sacs_top DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_sleep_instr(i_sleep_instr), .i_eni_instr(i_eni_instr),
		.i_global_irq_disable_instr_instr(i_global_irq_disable_instr_instr), .i_green_mode(i_green_mode),
		.i_sub_tick(i_sub_tick), .i_cmp_high(i_cmp_high),
		.o_trial_code(o_trial_code), .o_sample_enable(o_sample_enable),
		.o_channel_select(o_channel_select),
		.o_pin_function_bits(o_pin_function_bits),
		.o_sample_hold_select(o_sample_hold_select),
		.o_ref_pin_select(o_ref_pin_select),
		.o_ref_source_field(o_ref_source_field),
		.o_conv_active(o_conv_active), .o_core_sleep(o_core_sleep),
		.o_wake(o_wake), .o_resume_next(o_resume_next),
		.o_irq_request(o_irq_request), .o_irq_vector(o_irq_vector),
		.o_global_irq_enable(o_global_irq_enable));

	//////////////////////////////////////////////////////////////////////
	always #4 i_clock = ~i_clock;

	// sub clock: one pulse every five main cycles
	always @(posedge i_clock) begin
		sub_cnt <= (sub_cnt == 3'h4) ? 3'h0 : sub_cnt + 3'h1;
		i_sub_tick <= (sub_cnt == 3'h4);
	end

	//////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic do_reset();
		@(posedge i_clock);
		i_rst_b <= 1'b0;
		repeat (5) @(posedge i_clock);
		i_rst_b <= 1'b1;
	endtask : do_reset

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rchk(input string n, input logic [7:0] a,
		input logic [7:0] e);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		`SACS_CHK(n, e, o_rdata);
	endtask : rchk

	// one-cycle core event: {sleep, enable, disable}
	task automatic ev(input logic [2:0] s);
		@(posedge i_clock);
		{i_sleep_instr, i_eni_instr, i_global_irq_disable_instr_instr} <= s;
		@(posedge i_clock);
		{i_sleep_instr, i_eni_instr, i_global_irq_disable_instr_instr} <= 3'h0;
		@(negedge i_clock);
	endtask : ev

	// counts active cycles of a conversion and the pulses at its end
	task automatic wait_done(output int dur);
		int k;
		dur = 0;
		n_wake = 0;
		n_irq = 0;
		n_resume = 0;
		for (k = 0; k < 1200; k++) begin
			@(negedge i_clock);
			if (o_wake === 1'b1) n_wake++;
			if (o_irq_request === 1'b1) n_irq++;
			if (o_resume_next === 1'b1) n_resume++;
			if (o_conv_active === 1'b1) begin
				if (dur == 0 && !o_core_sleep) begin
					`SACS_CHK("first trial", 16'h0800, o_trial_code);
				end
				dur++;
			end else if (dur > 0) begin
				break;
			end
		end
		if (k == 1200) begin
			err_total++;
			close_out();
		end
	endtask : wait_done

	task automatic conv(input logic [2:0] r, input logic [11:0] v,
		output int dur);
		analog <= v;
		wr(OFS_CFG_ONE, {r, 5'h18});
		wait_done(dur);
		rchk("result high", OFS_RES_HI, {4'h0, v[11:8]});
		rchk("result low", OFS_RES_LO, v[7:0]);
		repeat (128) @(posedge i_clock);
	endtask : conv

	//////////////////////////////////////////////////////////////////////
	task automatic t_config();
		wr(OFS_CHANNEL, 8'hF5);
		wr(OFS_PIN_LO, 8'hA5);
		wr(OFS_PIN_HI, 8'hFF);
		wr(OFS_CFG_TWO, 8'hFF);
		wr(OFS_RES_HI, 8'hFF);
		wr(8'h77, 8'hFF);
		wr(OFS_CFG_ONE, 8'h02);
		@(negedge i_clock);
		`SACS_CHK("channel out", 16'h15, o_channel_select);
		`SACS_CHK("pins out", 16'h3FA5, o_pin_function_bits);
		`SACS_CHK("ref field", 16'h3, o_ref_source_field);
		`SACS_CHK("ref pin", 16'h1, o_ref_pin_select);
		`SACS_CHK("hold select", 16'h2, o_sample_hold_select);
		`SACS_CHK("sample off", 16'h0, o_sample_enable);
		rchk("channel", OFS_CHANNEL, 8'h15);
		rchk("pins high", OFS_PIN_HI, 8'h3F);
		rchk("config two", OFS_CFG_TWO, 8'h3E);
		rchk("result ro", OFS_RES_HI, 8'h00);
		rchk("unmapped", 8'h77, 8'h00);
		wr(OFS_CFG_ONE, 8'h10);
		@(negedge i_clock);
		`SACS_CHK("no start", 16'h0, o_conv_active);
		rchk("run refused", OFS_CFG_ONE, 8'h00);
	endtask : t_config

	task automatic t_basic();
		int d;
		wr(OFS_MASK, 8'h10);
		ev(3'b010);
		`SACS_CHK("global on", 16'h1, o_global_irq_enable);
		wr(OFS_CFG_ONE, 8'h88);
		repeat (128) @(posedge i_clock);
		analog <= 12'hA5C;
		wr(OFS_CFG_ONE, 8'h98);
		rchk("run busy", OFS_CFG_ONE, 8'h98);
		wait_done(d);
		`SACS_CHK("irq count", 16'h1, n_irq);
		`SACS_CHK("vector", 16'h10, o_irq_vector);
		rchk("run cleared", OFS_CFG_ONE, 8'h88);
		rchk("done flag", OFS_STATUS, 8'h10);
		rchk("res low", OFS_RES_LO, 8'h5C);
		wr(OFS_STATUS, 8'h10);
		rchk("flag kept", OFS_STATUS, 8'h10);
		wr(OFS_CHANNEL, 8'h03);
		rchk("cleared high", OFS_RES_HI, 8'h00);
		rchk("cleared low", OFS_RES_LO, 8'h00);
		wr(OFS_STATUS, 8'h00);
		rchk("flag clear", OFS_STATUS, 8'h00);
		wr(OFS_STATUS, 8'h10);
		rchk("flag no set", OFS_STATUS, 8'h00);
	endtask : t_basic

	task automatic t_rates();
		int dv[7] = '{16, 8, 4, 2, 64, 32, 1};
		int d, n;
		for (int c = 0; c < 9; c++) begin
			n = (c < 7) ? dv[c] : 5;
			i_green_mode <= (c == 8);
			conv((c < 7) ? c[2:0] : 3'h6 + c[0], 12'h5A3 + c[11:0], d);
			if (n == 1) begin
				`SACS_CHK("span div1", 16'd14, d);
			end else begin
				`SACS_CHK("span", 1, d >= 11 * n + 1 && d <= 12 * n + 5);
			end
		end
		i_green_mode <= 1'b0;
		conv(3'h6, 12'hFFF, d);
		conv(3'h6, 12'h000, d);
	endtask : t_rates

	// wake enable, global irq event, expected wake, irq, resume, asleep after
	task automatic t_sleep(input logic we, input logic [2:0] ge,
		input logic [3:0] e);
		int d;
		wr(OFS_WAKE, {3'h0, we, 4'h0});
		ev(ge);
		wr(OFS_CFG_ONE, 8'h18);
		ev(3'b100);
		`SACS_CHK("asleep", 16'h1, o_core_sleep);
		`SACS_CHK("still busy", 16'h1, o_conv_active);
		wait_done(d);
		`SACS_CHK("wake", e[3], n_wake);
		`SACS_CHK("vector", e[2], n_irq);
		`SACS_CHK("resume", e[1], n_resume);
		@(negedge i_clock);
		`SACS_CHK("sleep after", e[0], o_core_sleep);
		`SACS_CHK("sampling", !e[0], o_sample_enable);
	endtask : t_sleep

	//////////////////////////////////////////////////////////////////////
	initial begin
		i_clock = 1'b0;
		i_rst_b = 1'b0;
		{i_wr, i_rd, i_green_mode, i_sub_tick} = 4'h0;
		{i_sleep_instr, i_eni_instr, i_global_irq_disable_instr_instr} = 3'h0;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		analog = 12'h000;
		sub_cnt = 3'h0;
		err_total = 0;
		checks_done = 0;
		do_reset();
		rchk("reset cfg", OFS_CFG_ONE, 8'h00);
		rchk("reset flag", OFS_STATUS, 8'h00);
		rchk("reset result", OFS_RES_LO, 8'h00);
		t_config();
		t_basic();
		t_rates();
		t_sleep(1'b1, 3'b001, 4'b1010);
		t_sleep(1'b1, 3'b010, 4'b1100);
		t_sleep(1'b0, 3'b010, 4'b0001);
		do_reset();
		@(negedge i_clock);
		`SACS_CHK("reset sleep", 16'h0, o_core_sleep);
		rchk("reset wake", OFS_WAKE, 8'h00);
		close_out();
	end

endmodule : sacs_top_bench
